// file: core/isr_map.vh
// Purpose: constants for the instrument status reporting block
// Assumes: included by isr_top.v
// Notes: register selectors are local choices
`ifndef ISR_MAP_VH
`define ISR_MAP_VH
`define ISR_SEL_QLIVE 4'h0
`define ISR_SEL_QEVT 4'h1
`define ISR_SEL_QMASK 4'h2
`define ISR_SEL_OLIVE 4'h3
`define ISR_SEL_OEVT 4'h4
`define ISR_SEL_OMASK 4'h5
`define ISR_SEL_STB 4'h6
`define ISR_SEL_SEVT 4'h7
`define ISR_SEL_SMASK 4'h8
`define ISR_SEL_SRMASK 4'h9
`define ISR_SEL_ERRQ 4'ha
`define ISR_Q_VOLT 0
`define ISR_Q_CURR 1
`define ISR_Q_OVP 9
`define ISR_Q_USED 16'h0203
`define ISR_STB_ERRQ 2
`define ISR_STB_DOUBT 3
`define ISR_STB_RESP 4
`define ISR_STB_SEVT 5
`define ISR_STB_RQS 6
`define ISR_STB_ACT 7
`define ISR_SEV_OPC 0
`define ISR_SEV_QYE 2
`define ISR_SEV_DDE 3
`define ISR_SEV_EXE 4
`define ISR_SEV_CME 5
`define ISR_SEV_BTN 6
`define ISR_SEV_PON 7
`define ISR_SEV_USED 8'hfd
`define ISR_ERR_OVERFLOW 16'hfea2
`define ISR_ERR_NONE 16'h0000
`define ISR_ZERO16 16'h0000
`define ISR_ZERO8 8'h00
`define ISR_QDEPTH 8
`define ISR_QPTRW 3
`endif

// file: core/isr_top.v
// Purpose: status byte, event groups, masks, service request, error queue
// Assumes: command decoding done elsewhere; single sys_clk domain
// Notes: register reads answer one cycle after the read strobe
// Operation
// - two groups, each with live, latched and mask 16-bit registers
// - live bits follow conditions, read-only, no latching
// - event bit sets on rising condition, holds until read or clear
// - doubtful bits 0 voltage, 1 current, 9 overvoltage; rest zero
// - reading doubtful live register changes nothing
// - reading doubtful event register returns then clears it
// - activity group present but never driven; stays zero
// - status byte field placement, bits 0 and 1 zero
// - bit 2 high while error queue holds entries
// - bit 3 doubtful summary, bit 7 activity summary
// - bit 4 high while unread response data waits
// - bit 6 service request, readable by poll or query
// - standard event bit 0 sets when pending operations finish
// - standard event bit assignments, bit 1 always zero
// - reading standard event register returns then clears it
// - summary is OR of event bits ANDed with enables
// - standard event mask gates status byte bit 5, writable, readable
// - doubtful mask gates doubtful summary, writable, readable
// - service request mask selects status bits requesting service
// - output queue cleared when new message follows terminator
// - error queue FIFO, one per read, overflow records code and blocks
// - entries carry standard negative codes
// - enabled status bit drives service request line
`timescale 1ns/10ps
`default_nettype none
`include "isr_map.vh"
module isr_top (
    input wire sys_clk,
    input wire reset,
    input wire volt_cond,
    input wire curr_cond,
    input wire ovp_cond,
    input wire opc_armed,
    input wire ops_idle,
    input wire ev_query_err,
    input wire ev_device_err,
    input wire ev_exec_err,
    input wire ev_parse_err,
    input wire local_button,
    input wire power_up_pulse,
    input wire clear_status,
    input wire resp_push,
    input wire resp_pull,
    input wire msg_after_term,
    input wire err_push,
    input wire [15:0] err_code,
    input wire reg_rd,
    input wire reg_wr,
    input wire [3:0] reg_sel,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    output reg reg_rvalid,
    output reg service_request,
    output reg [7:0] summary_status_byte
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [9:0] sync_a;
    reg [9:0] sync_b;
    wire [9:0] pins = {power_up_pulse, local_button, ev_parse_err, ev_exec_err,
        ev_device_err, ev_query_err, ops_idle, curr_cond, ovp_cond, volt_cond};
    always @(posedge sys_clk) begin
        if (reset) begin
            sync_a <= 10'h000;
            sync_b <= 10'h000;
        end else begin
            sync_a <= pins;
            sync_b <= sync_a;
        end
    end
    reg [9:0] sync_d;
    always @(posedge sys_clk) begin
        if (reset)
            sync_d <= 10'h000;
        else
            sync_d <= sync_b;
    end
    wire [9:0] rise = sync_b & ~sync_d;

    function summ16;
        input [15:0] ev;
        input [15:0] en;
        begin
            summ16 = |(ev & en);
        end
    endfunction

    // ------------------------------------------------------------
    // doubtful and activity groups
    // ------------------------------------------------------------
    // live state follows
    wire [15:0] doubtful_live = {6'h00, sync_b[1], 7'h00, sync_b[2], sync_b[0]};
    wire [15:0] doubtful_prev = {6'h00, sync_d[1], 7'h00, sync_d[2], sync_d[0]};
    wire [15:0] activity_live = `ISR_ZERO16;
    reg [15:0] doubtful_event_flags;
    reg [15:0] doubtful_mask;
    reg [15:0] activity_event_flags;
    reg [15:0] activity_mask;
    wire rd_qevt = reg_rd && (reg_sel == `ISR_SEL_QEVT);
    wire rd_oevt = reg_rd && (reg_sel == `ISR_SEL_OEVT);
    wire rd_sevt = reg_rd && (reg_sel == `ISR_SEL_SEVT);
    wire rd_errq = reg_rd && (reg_sel == `ISR_SEL_ERRQ);
    wire [15:0] q_rise = doubtful_live & ~doubtful_prev & `ISR_Q_USED;
    always @(posedge sys_clk) begin
        if (reset) begin
            doubtful_event_flags <= `ISR_ZERO16;
            activity_event_flags <= `ISR_ZERO16;
        end else begin
            if (clear_status || rd_qevt)
                doubtful_event_flags <= q_rise;
            else
                doubtful_event_flags <= doubtful_event_flags | q_rise;
            activity_event_flags <= (clear_status || rd_oevt) ? `ISR_ZERO16 :
                (activity_event_flags | activity_live);
        end
    end
    always @(posedge sys_clk) begin
        if (reset) begin
            doubtful_mask <= `ISR_ZERO16;
            activity_mask <= `ISR_ZERO16;
        end else if (reg_wr) begin
            if (reg_sel == `ISR_SEL_QMASK)
                doubtful_mask <= reg_wdata;
            if (reg_sel == `ISR_SEL_OMASK)
                activity_mask <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // standard events
    // ------------------------------------------------------------
    reg [7:0] standard_event_flags;
    reg [7:0] standard_event_mask;
    reg [7:0] service_request_mask;
    reg opc_wait;
    wire opc_done = opc_wait && sync_b[3];
    wire [7:0] sev_set = {rise[9], rise[8], rise[7], rise[6], rise[5], rise[4],
        1'b0, opc_done};
    always @(posedge sys_clk) begin
        if (reset)
            opc_wait <= 1'b0;
        else if (opc_armed)
            opc_wait <= 1'b1;
        else if (opc_done)
            opc_wait <= 1'b0;
    end
    always @(posedge sys_clk) begin
        if (reset)
            standard_event_flags <= `ISR_ZERO8;
        // clear on read, new set kept
        else if (clear_status || rd_sevt)
            standard_event_flags <= sev_set & `ISR_SEV_USED;
        else
            standard_event_flags <= (standard_event_flags | sev_set) & `ISR_SEV_USED;
    end
    always @(posedge sys_clk) begin
        if (reset) begin
            standard_event_mask <= `ISR_ZERO8;
            service_request_mask <= `ISR_ZERO8;
        end else if (reg_wr) begin
            if (reg_sel == `ISR_SEL_SMASK)
                standard_event_mask <= reg_wdata[7:0];
            if (reg_sel == `ISR_SEL_SRMASK)
                service_request_mask <= reg_wdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // response pending
    // ------------------------------------------------------------
    reg [7:0] resp_count;
    always @(posedge sys_clk) begin
        if (reset)
            resp_count <= 8'h00;
        else if (msg_after_term)
            resp_count <= resp_push ? 8'h01 : 8'h00;
        else if (resp_push && !resp_pull && resp_count != 8'hff)
            resp_count <= resp_count + 8'h01;
        else if (resp_pull && !resp_push && resp_count != 8'h00)
            resp_count <= resp_count - 8'h01;
    end

    // ------------------------------------------------------------
    // error queue
    // ------------------------------------------------------------
    // depth fixed, last slot kept for overflow code
    reg [15:0] err_mem [0:`ISR_QDEPTH-1];
    reg [`ISR_QPTRW-1:0] wr_ptr;
    reg [`ISR_QPTRW-1:0] rd_ptr;
    reg [`ISR_QPTRW:0] err_count;
    reg err_blocked;
    wire q_empty = (err_count == 4'h0);
    wire do_pop = rd_errq && !q_empty;
    wire [`ISR_QPTRW:0] cnt_after = do_pop ? err_count - 4'h1 : err_count;
    wire room = (cnt_after < 4'h7);
    wire last = (cnt_after == 4'h7);
    wire do_push = err_push && !err_blocked && (room || last);
    wire [15:0] push_code = room ? err_code : `ISR_ERR_OVERFLOW;
    always @(posedge sys_clk) begin
        if (do_push)
            err_mem[wr_ptr] <= push_code;
    end
    always @(posedge sys_clk) begin
        if (reset || clear_status) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            err_count <= 4'h0;
            err_blocked <= 1'b0;
        end else begin
            if (do_push)
                wr_ptr <= wr_ptr + 3'h1;
            if (do_pop)
                rd_ptr <= rd_ptr + 3'h1;
            err_count <= cnt_after + (do_push ? 4'h1 : 4'h0);
            if (do_pop)
                err_blocked <= 1'b0;
            else if (do_push && !room)
                err_blocked <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // status byte and service request
    // ------------------------------------------------------------
    // masked OR summaries
    reg [7:0] next_stb;
    always @* begin
        next_stb = `ISR_ZERO8;
        next_stb[`ISR_STB_ACT] = summ16(activity_event_flags, activity_mask);
        next_stb[`ISR_STB_DOUBT] = summ16(doubtful_event_flags, doubtful_mask);
        next_stb[`ISR_STB_SEVT] = |(standard_event_flags & standard_event_mask);
        next_stb[`ISR_STB_RESP] = (resp_count != 8'h00);
        next_stb[`ISR_STB_ERRQ] = !q_empty;
        next_stb[`ISR_STB_RQS] = |(next_stb & service_request_mask & 8'hbf);
    end
    always @(posedge sys_clk) begin
        if (reset) begin
            summary_status_byte <= `ISR_ZERO8;
            service_request <= 1'b0;
        end else begin
            summary_status_byte <= next_stb;
            service_request <= next_stb[`ISR_STB_RQS];
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    reg [15:0] next_rdata;
    always @* begin
        case (reg_sel)
            // live read has no side effect
            `ISR_SEL_QLIVE: next_rdata = doubtful_live;
            `ISR_SEL_QEVT: next_rdata = doubtful_event_flags;
            `ISR_SEL_QMASK: next_rdata = doubtful_mask;
            `ISR_SEL_OLIVE: next_rdata = activity_live;
            `ISR_SEL_OEVT: next_rdata = activity_event_flags;
            `ISR_SEL_OMASK: next_rdata = activity_mask;
            `ISR_SEL_STB: next_rdata = {8'h00, summary_status_byte};
            `ISR_SEL_SEVT: next_rdata = {8'h00, standard_event_flags};
            `ISR_SEL_SMASK: next_rdata = {8'h00, standard_event_mask};
            `ISR_SEL_SRMASK: next_rdata = {8'h00, service_request_mask};
            `ISR_SEL_ERRQ: next_rdata = q_empty ? `ISR_ERR_NONE : err_mem[rd_ptr];
            default: next_rdata = `ISR_ZERO16;
        endcase
    end
    always @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= `ISR_ZERO16;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= next_rdata;
        end
    end
endmodule // isr_top
`default_nettype wire

// file: dv/isr_ctl_model.sv
// Purpose: remote controller issuing register commands and queries
// Assumes: one access per go pulse, registered toward the block
// Notes: released select and data lines show inverted last values
`timescale 1ns/10ps
`default_nettype none
module isr_ctl_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic go,
    input wire logic wr,
    input wire logic [3:0] sel,
    input wire logic [15:0] wdata,
    output logic reg_rd,
    output logic reg_wr,
    output logic [3:0] reg_sel,
    output logic [15:0] reg_wdata
);
    always @(posedge sys_clk) begin
        reg_rd <= go & ~wr & ~reset;
        reg_wr <= go & wr & ~reset;
        reg_sel <= go ? sel : ~reg_sel;
        reg_wdata <= go ? wdata : ~reg_wdata;
    end
endmodule // isr_ctl_model
`default_nettype wire

// file: dv/isr_top_properties.sv
// Purpose: port checker for the status reporting block
// Assumes: selector and bit constants from the block header
// Notes: mask-dependent bits are checked by the bench
`timescale 1ns/10ps
`default_nettype none
`include "isr_map.vh"
module isr_top_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic err_push,
    input wire logic clear_status,
    input wire logic resp_push,
    input wire logic resp_pull,
    input wire logic msg_after_term,
    input wire logic reg_rd,
    input wire logic [3:0] reg_sel,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [7:0] summary_status_byte
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    rd_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    low_bits_a: assert property (summary_status_byte[1:0] == 2'h0)
        else $error("status bits 1:0 set");
    act_summary_a: assert property (!summary_status_byte[7])
        else $error("activity summary set");
    errq_flag_a: assert property (err_push && !clear_status |-> ##2 summary_status_byte[2])
        else $error("error flag missing");
    errq_clear_a:
        assert property ((clear_status && !err_push) ##1 !err_push |-> ##1 !summary_status_byte[2])
        else $error("error flag after clear");
    resp_flag_a:
        assert property (resp_push && !resp_pull && !msg_after_term |-> ##2 summary_status_byte[4])
        else $error("response flag missing");
    resp_drop_a: assert property (msg_after_term && !resp_push |-> ##2 !summary_status_byte[4])
        else $error("response flag kept");
    live_unused_a:
        assert property (reg_rd && reg_sel == `ISR_SEL_QLIVE |=> (reg_rdata & ~`ISR_Q_USED) == 0)
        else $error("unused live bit set");
    unmapped_rd_a: assert property (reg_rd && reg_sel > 4'ha |=> reg_rdata == 16'h0000)
        else $error("unmapped read nonzero");
    std_unused_a:
        assert property (reg_rd && reg_sel == `ISR_SEL_SEVT |=> (reg_rdata & 16'hff02) == 0)
        else $error("unused event bit set");
endmodule // isr_top_chk
bind isr_top isr_top_chk i_chk (.sys_clk(sys_clk), .reset(reset), .err_push(err_push),
    .clear_status(clear_status), .resp_push(resp_push), .resp_pull(resp_pull),
    .msg_after_term(msg_after_term), .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .summary_status_byte(summary_status_byte));
`default_nettype wire

// file: dv/tb.sv
// Purpose: self-checking bench for the status reporting block
// Assumes: controller model turns go pulses into register accesses
// Notes: read results are checked in order off a queue
`timescale 1ns/10ps
`default_nettype none
module tb;
logic sys_clk = 0, reset = 1, go = 0, wr = 0, volt = 0, curr = 0, overvoltage_protection = 0, operations_done_flag = 0;
logic clr = 0, rpush = 0, rpull = 0, term = 0, epush = 0, idle = 1;
logic [5:0] sev = 0;
logic [3:0] sel = 0, reg_sel;
logic [15:0] wd = 0, ecode = 0, reg_wdata, reg_rdata;
logic reg_rd, reg_wr, reg_rvalid, service_request;
logic [7:0] summary_status_byte;
logic [15:0] expq[$];
logic [31:0] seed = 32'h3bc6;
logic [3:0] zs[10] = '{4'h2, 4'h5, 4'h8, 4'h9, 4'hb, 4'hf, 4'h0, 4'h3, 4'h6, 4'h7};
logic [3:0] ms[4] = '{4'h2, 4'h5, 4'h8, 4'h9};
logic [15:0] mk[4] = '{16'hffff, 16'hffff, 16'h00ff, 16'h00bf};
logic [15:0] codes[9] = '{16'hff9a, 16'hff90, 16'hff22, 16'hfeb6, 16'hff9b, 16'hff99,
    16'hff98, 16'hff97, 16'hff93};
int n_errors = 0, checks = 0;
always #4 sys_clk = ~sys_clk;
isr_ctl_model i_ctl (.sys_clk(sys_clk), .reset(reset), .go(go), .wr(wr), .sel(sel),
    .wdata(wd), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata));
isr_top i_dut (.sys_clk(sys_clk), .reset(reset), .volt_cond(volt), .curr_cond(curr),
    .ovp_cond(overvoltage_protection), .opc_armed(operations_done_flag), .ops_idle(idle), .ev_query_err(sev[0]),
    .ev_device_err(sev[1]), .ev_exec_err(sev[2]), .ev_parse_err(sev[3]),
    .local_button(sev[4]), .power_up_pulse(sev[5]), .clear_status(clr), .resp_push(rpush),
    .resp_pull(rpull), .msg_after_term(term), .err_push(epush), .err_code(ecode),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .service_request(service_request),
    .summary_status_byte(summary_status_byte));
function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
endfunction
task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
        n_errors++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
endtask
// reads carry their expected value in d
task automatic acc(input logic w, input logic [3:0] s, input logic [15:0] d);
    go <= 1;
    wr <= w;
    sel <= s;
    wd <= d;
    if (!w) expq.push_back(d);
    tick(1);
    go <= 0;
    tick(3);
endtask
// one-cycle strobe: 0 clear, 1 arm, 2 error push, 3 resp push, 4 terminator, else pull
task automatic pulse(input int k);
    case (k)
        0: clr <= 1;
        1: operations_done_flag <= 1;
        2: epush <= 1;
        3: rpush <= 1;
        4: term <= 1;
        default: rpull <= 1;
    endcase
    tick(1);
    {clr, operations_done_flag, epush, rpush, term, rpull} <= 6'h00;
    tick(2);
endtask
task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
always @(posedge sys_clk) if (reg_rvalid === 1'b1) cmp(reg_rdata, expq.size() ? expq.pop_front() : 16'hxxxx);
initial begin
    #100000;
    n_errors++;
    conclude;
end
initial begin
    tick(5);
    reset <= 0;
    tick(1);
    for (int i = 0; i < 10; i++) acc(0, zs[i], 16'h0000);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
        seed = lfsr(seed);
        acc(1, ms[i], seed[15:0] & mk[i]);
        acc(0, ms[i], seed[15:0] & mk[i]);
    end
    acc(1, 4'h2, 16'h0200);
    acc(1, 4'h9, 16'h0008);
    acc(1, 4'h8, 16'h0080);
    $display("mask access done");
    volt <= 1;
    curr <= 1;
    overvoltage_protection <= 1;
    tick(8);
    acc(0, 4'h0, 16'h0203);
    acc(0, 4'h6, 16'h0048);
    cmp({15'h0, service_request}, 16'h0001);
    acc(0, 4'h1, 16'h0203);
    acc(0, 4'h1, 16'h0000);
    acc(0, 4'h6, 16'h0000);
    acc(0, 4'h0, 16'h0203);
    overvoltage_protection <= 0;
    tick(4);
    overvoltage_protection <= 1;
    tick(6);
    pulse(0);
    acc(0, 4'h1, 16'h0000);
    {volt, curr, overvoltage_protection} <= 3'h0;
    $display("doubtful group done");
    for (int i = 0; i < 6; i++) begin
        sev[i] <= 1;
        tick(6);
        if (i == 5) acc(0, 4'h6, 16'h0020);
        acc(0, 4'h7, 16'h0004 << i);
        sev[i] <= 0;
    end
    idle <= 0;
    tick(3);
    pulse(1);
    tick(4);
    acc(0, 4'h7, 16'h0000);
    idle <= 1;
    tick(4);
    acc(0, 4'h7, 16'h0001);
    $display("standard events done");
    for (int i = 0; i < 9; i++) begin
        ecode <= codes[i];
        epush <= 1;
        tick(1);
    end
    epush <= 0;
    tick(3);
    acc(0, 4'h6, 16'h0004);
    for (int i = 0; i < 8; i++) acc(0, 4'ha, i < 7 ? codes[i] : 16'hfea2);
    acc(0, 4'ha, 16'h0000);
    pulse(2);
    pulse(0);
    acc(0, 4'h6, 16'h0000);
    acc(0, 4'ha, 16'h0000);
    $display("error queue done");
    pulse(3);
    acc(0, 4'h6, 16'h0010);
    pulse(4);
    acc(0, 4'h6, 16'h0000);
    rpush <= 1;
    tick(2);
    rpush <= 0;
    pulse(5);
    acc(0, 4'h6, 16'h0010);
    pulse(5);
    acc(0, 4'h6, 16'h0000);
    $display("response flag done");
    conclude;
end
endmodule // tb
`default_nettype wire
